// >>> hw/sosd_chan.sv
// one safety output channel: off pulse, fault detection, overcurrent shut-off and error hold
`timescale 1ns/100ps
`include "sosd_regs.svh"
module sosd_chan #(
    parameter int PULSE_CYC = 64000,
    parameter int PERIOD_CYC = 10000000,
    parameter int HOLD_CYC = 100000000
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cmd,
    input wire logic pulse_en,
    input wire logic force_off,
    input wire logic pair_fault,
    input wire logic fb_high,
    input wire logic overcurrent,
    input wire logic other_on,
    input wire logic other_fb_high,
    output logic drive,
    output logic fault,
    output logic short_ev,
    output logic wire_ev
);
    logic [31:0] pcnt;
    logic [31:0] next_pcnt;
    logic [31:0] hcnt;
    logic [31:0] next_hcnt;
    logic in_pulse;
    logic next_in_pulse;
    logic held;
    logic next_held;
    logic wire_err;
    logic ev;
    // copy of what the pin shows now; readback is judged against it, not against cmd
    logic drive_q;
    // -----------------------------------------------
    // fault classification
    // -----------------------------------------------
    always_comb
    begin
        wire_err = 1'b0;
        // high while off counts only if off was asked for, or off pulses are enabled
        if (!drive_q && fb_high && (!cmd || pulse_en))
            wire_err = 1'b1;
        if (drive_q && !fb_high)
            wire_err = 1'b1;
        if (!drive_q && other_on && fb_high && other_fb_high)
            wire_err = 1'b1;
        ev = wire_err | overcurrent;
    end
    // -----------------------------------------------
    // pulse timing and error hold
    // -----------------------------------------------
    always_comb
    begin
        next_pcnt = pcnt + 32'h1;
        next_in_pulse = in_pulse;
        next_held = held;
        next_hcnt = hcnt;
        if (!pulse_en || !cmd)
        begin
            next_pcnt = 32'h0;
            next_in_pulse = 1'b0;
        end
        else if (in_pulse && pcnt >= 32'(PULSE_CYC - 1))
        begin
            next_pcnt = 32'h0;
            next_in_pulse = 1'b0;
        end
        else if (!in_pulse && pcnt >= 32'(PERIOD_CYC - 1))
        begin
            next_pcnt = 32'h0;
            next_in_pulse = 1'b1;
        end
        if (ev)
        begin
            next_held = 1'b1;
            next_hcnt = 32'h0;
        end
        else if (held && hcnt >= 32'(HOLD_CYC - 1))
            next_held = 1'b0;
        else if (held)
            next_hcnt = hcnt + 32'h1;
    end
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pcnt <= 32'h0;
            hcnt <= 32'h0;
            in_pulse <= 1'b0;
            held <= 1'b0;
            drive <= 1'b0;
            drive_q <= 1'b0;
            fault <= 1'b0;
            short_ev <= 1'b0;
            wire_ev <= 1'b0;
        end
        else
        begin
            pcnt <= next_pcnt;
            hcnt <= next_hcnt;
            in_pulse <= next_in_pulse;
            held <= next_held;
            drive <= cmd && !next_in_pulse && !force_off && !pair_fault && !next_held && !overcurrent;
            drive_q <= drive;
            fault <= next_held;
            short_ev <= overcurrent;
            wire_ev <= wire_err;
        end
    end
    AST_OC_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        overcurrent |=> !drive) else $error("drive stayed on after overcurrent");
    AST_OC_EV: assert property (@(posedge ref_clk) disable iff (!arst_n)
        overcurrent |=> short_ev) else $error("short event missing");
    AST_NO_PULSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !pulse_en |=> !in_pulse) else $error("pulse while diagnosis off");
    AST_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(held) |-> hcnt >= 32'(HOLD_CYC - 1)) else $error("error hold too short");
    AST_PW: assert property (@(posedge ref_clk) disable iff (!arst_n)
        in_pulse |-> pcnt < 32'(PULSE_CYC)) else $error("off pulse too long");
endmodule // sosd_chan

// >>> hw/sosd_top.sv
// safety output self-diagnosis supervisor with APB register access
`timescale 1ns/100ps
`include "sosd_regs.svh"
module sosd_top import sosd_pkg::*; #(
    parameter int N = 4,
    parameter int PULSE_CYC = `SOSD_PULSE_US * `SOSD_CLK_MHZ,
    parameter int PERIOD_CYC = `SOSD_PULSE_PERIOD_US * `SOSD_CLK_MHZ,
    parameter int HOLD_CYC = `SOSD_HOLD_MS * 1000 * `SOSD_CLK_MHZ,
    parameter int TEST_CYC = `SOSD_TEST_WAIT_US * `SOSD_CLK_MHZ
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N-1:0] out_fb_high,
    input wire logic [N-1:0] out_overcurrent,
    input wire logic supply_present,
    input wire logic supply_in_range,
    output logic [N-1:0] out_drive,
    output logic supply_cut,
    output logic irq
);
    logic [31:0] ctrl;
    logic [31:0] mode;
    logic [31:0] unused;
    logic [31:0] data;
    logic [`SOSD_IRQ_W-1:0] stat;
    logic [`SOSD_IRQ_W-1:0] next_stat;
    logic [`SOSD_IRQ_W-1:0] mask;
    logic [N-1:0] drv;
    logic [N-1:0] flt;
    logic [N-1:0] sev;
    logic [N-1:0] wev;
    logic [N-1:0] pair_flt;
    logic [N-1:0] cmd_eff;
    logic volt_err;
    logic supervise;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rdata;
    sosd_test_t tst;
    sosd_test_t next_tst;
    logic done;
    logic next_done;
    logic [31:0] tcnt;
    logic [31:0] next_tcnt;
    logic refreshing;
    // -----------------------------------------------
    // apb slave, zero wait states
    // -----------------------------------------------
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    always_comb
    begin
        hit = 1'b1;
        rdata = 32'h0;
        unique case (paddr)
            `SOSD_CTRL_OFS: rdata = ctrl;
            `SOSD_MODE_OFS: rdata = mode;
            `SOSD_UNUSED_OFS: rdata = unused;
            `SOSD_CMD_OFS: rdata = data;
            `SOSD_STAT_OFS: rdata = 32'({tst == SOSD_T_FAIL, done, volt_err, 1'b0} << 0) | 32'(drv) << 8;
            `SOSD_IRQ_OFS: rdata = 32'(stat);
            `SOSD_MASK_OFS: rdata = 32'(mask);
            `SOSD_FAULT_OFS: rdata = 32'(flt);
            default: hit = 1'b0;
        endcase
    end
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl <= 32'h0;
            mode <= 32'h0;
            unused <= 32'h0;
            data <= 32'h0;
            mask <= '0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (rd && !penable)
                prdata <= rdata;
            if (wr && pready)
            begin
                unique case (paddr)
                    `SOSD_CTRL_OFS: ctrl <= pwdata;
                    `SOSD_MODE_OFS: mode <= pwdata;
                    `SOSD_UNUSED_OFS: unused <= pwdata;
                    `SOSD_CMD_OFS: data <= pwdata;
                    `SOSD_MASK_OFS: mask <= pwdata[`SOSD_IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
    end
    // -----------------------------------------------
    // supply supervision and interrupts
    // -----------------------------------------------
    assign refreshing = ctrl[`SOSD_CTRL_REFRESH_BIT];
    assign supervise = ~&unused[N-1:0];
    assign volt_err = supervise && supply_present && !supply_in_range;
    always_comb
    begin
        next_stat = stat;
        if (wr && pready && paddr == `SOSD_IRQ_OFS)
            next_stat = stat & ~pwdata[`SOSD_IRQ_W-1:0];
        if (|sev)
            next_stat[`SOSD_IRQ_SHORT_BIT] = 1'b1;
        if (volt_err)
            next_stat[`SOSD_IRQ_VOLT_BIT] = 1'b1;
        if (|wev)
            next_stat[`SOSD_IRQ_WIRE_BIT] = 1'b1;
        if (tst == SOSD_T_FAIL)
            next_stat[`SOSD_IRQ_CUTOFF_BIT] = 1'b1;
    end
    // -----------------------------------------------
    // supply cut-off circuit test
    // -----------------------------------------------
    always_comb
    begin
        next_tst = tst;
        next_done = done;
        next_tcnt = tcnt + 32'h1;
        unique case (tst)
            SOSD_T_IDLE:
            begin
                next_tcnt = 32'h0;
                if (!done && refreshing && supply_present)
                    next_tst = SOSD_T_CUT;
            end
            SOSD_T_CUT:
            begin
                if (!supply_present)
                begin
                    next_tst = SOSD_T_WAIT;
                    next_tcnt = 32'h0;
                end
                else if (tcnt >= 32'(TEST_CYC - 1))
                    next_tst = SOSD_T_FAIL;
            end
            SOSD_T_WAIT:
            begin
                next_tst = SOSD_T_PASS;
            end
            SOSD_T_PASS:
            begin
                next_done = 1'b1;
                next_tst = SOSD_T_IDLE;
            end
            SOSD_T_FAIL:
            begin
                next_done = 1'b1;
            end
            default: next_tst = SOSD_T_FAIL;
        endcase
    end
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tst <= SOSD_T_IDLE;
            done <= 1'b0;
            tcnt <= 32'h0;
            stat <= '0;
            irq <= 1'b0;
            supply_cut <= 1'b0;
            out_drive <= '0;
        end
        else
        begin
            tst <= next_tst;
            done <= next_done;
            tcnt <= next_tcnt;
            stat <= next_stat;
            irq <= |(next_stat & ~mask);
            supply_cut <= next_tst == SOSD_T_CUT;
            out_drive <= drv;
        end
    end
    // -----------------------------------------------
    // channels
    // -----------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ch
            localparam int P = g ^ 1;
            assign cmd_eff[g] = mode[g / 2] ? data[g & ~1] : data[g];
            assign pair_flt[g] = mode[g / 2] && flt[P];
            sosd_chan #(
                .PULSE_CYC(PULSE_CYC),
                .PERIOD_CYC(PERIOD_CYC),
                .HOLD_CYC(HOLD_CYC)
            ) u_ch (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .cmd(cmd_eff[g] && !unused[g]),
                .pulse_en(ctrl[`SOSD_CTRL_PULSE_BIT]),
                .force_off(volt_err || tst != SOSD_T_IDLE || !done),
                .pair_fault(pair_flt[g]),
                .fb_high(out_fb_high[g]),
                .overcurrent(out_overcurrent[g]),
                .other_on(cmd_eff[P]),
                .other_fb_high(out_fb_high[P]),
                .drive(drv[g]),
                .fault(flt[g]),
                .short_ev(sev[g]),
                .wire_ev(wev[g])
            );
        end
    endgenerate
    AST_VOLT_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        volt_err |-> ##2 out_drive == '0) else $error("outputs on during supply error");
    AST_VOLT_IRQ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        volt_err |=> stat[`SOSD_IRQ_VOLT_BIT]) else $error("voltage flag not set");
    AST_UNUSED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        &unused[N-1:0] |-> !volt_err) else $error("supervision while all unused");
    AST_ONCE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        done |-> tst != SOSD_T_CUT) else $error("cut-off test repeated");
    // -----------------------------------------------
    // cut-off test steps
    // -----------------------------------------------
    sequence s_test_launch;
        tst == SOSD_T_IDLE && !done && refreshing && supply_present;
    endsequence
    sequence s_supply_dropped;
        tst == SOSD_T_CUT && !supply_present;
    endsequence
    sequence s_cut_stuck;
        tst == SOSD_T_CUT && supply_present && tcnt >= 32'(TEST_CYC - 1);
    endsequence
    AST_START: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_test_launch |=> supply_cut)
        else $error("cut-off test not launched");
    AST_PASS_DONE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_supply_dropped |=> ##1 tst == SOSD_T_PASS ##1 done)
        else $error("passed test not recorded");
    AST_TIMEOUT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_cut_stuck |=> tst == SOSD_T_FAIL)
        else $error("dead cut-off path not caught");
    // outputs are held off until the cut-off path has proven itself
    AST_TEST_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !done |-> ##2 out_drive == '0) else $error("outputs on before test passed");
    AST_FAIL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tst == SOSD_T_FAIL |-> ##2 out_drive == '0) else $error("outputs on after failed test");
endmodule // sosd_top

// >>> inc/sosd_pkg.sv
// types of the safety output supervisor
package sosd_pkg;
    typedef enum logic [4:0] {
        SOSD_T_IDLE = 5'b00001,
        SOSD_T_WAIT = 5'b00010,
        SOSD_T_CUT = 5'b00100,
        SOSD_T_PASS = 5'b01000,
        SOSD_T_FAIL = 5'b10000
    } sosd_test_t;
endpackage

// >>> inc/sosd_regs.svh
// register offsets, field positions and timing values of the safety output supervisor
// How it works
// - off pulses only when diagnosis enabled, output ON
// - pulse mode flags high ON/OFF, ground, shorts
// - no-pulse mode flags high OFF, ground, mixed short
// - overcurrent turns that terminal OFF
// - overcurrent raises distinct short-circuit event
// - supply out of range forces all outputs OFF
// - supply out of range sets voltage error
// - no supply supervision when all terminals unused
// - cut-off test removes supply and checks it
// - cut-off test once per power-on only
// - supply present early: test at refreshing entry
// - supply later: test when supply turns on
// - each off pulse lasts 640 us
// - dual mode fault turns both pair terminals OFF
// - error state held at least one second
`ifndef SOSD_REGS_SVH
`define SOSD_REGS_SVH
`define SOSD_CTRL_OFS 12'h000
`define SOSD_MODE_OFS 12'h004
`define SOSD_UNUSED_OFS 12'h008
`define SOSD_CMD_OFS 12'h00C
`define SOSD_STAT_OFS 12'h010
`define SOSD_IRQ_OFS 12'h014
`define SOSD_MASK_OFS 12'h018
`define SOSD_FAULT_OFS 12'h01C
`define SOSD_CTRL_PULSE_BIT 0
`define SOSD_CTRL_REFRESH_BIT 1
`define SOSD_IRQ_SHORT_BIT 0
`define SOSD_IRQ_VOLT_BIT 1
`define SOSD_IRQ_WIRE_BIT 2
`define SOSD_IRQ_CUTOFF_BIT 3
`define SOSD_IRQ_W 4
`define SOSD_PULSE_US 640
`define SOSD_HOLD_MS 1000
`define SOSD_CLK_MHZ 100
`define SOSD_TEST_WAIT_US 1000
`define SOSD_PULSE_PERIOD_US 100000
`endif

// >>> sim/sosd_partner.sv
// model of the output devices and the switchable I/O supply
`timescale 1ns/100ps
module sosd_partner #(
    parameter int N = 4
) (
    input wire logic [N-1:0] out_drive,
    input wire logic supply_cut,
    input wire logic supply_on,
    input wire logic cut_works,
    input wire logic volt_ok,
    input wire logic [N-1:0] stuck_hi,
    input wire logic [N-1:0] gnd_flt,
    input wire logic short01,
    input wire logic [N-1:0] oc_flt,
    output logic [N-1:0] out_fb_high,
    output logic [N-1:0] out_overcurrent,
    output logic supply_present,
    output logic supply_in_range
);
    // ----------------
    // lines and supply
    // ----------------
    always_comb
    begin
        out_fb_high = out_drive;
        // a short lets either drive lift both lines
        if (short01)
        begin
            out_fb_high[1:0] = {2{|out_drive[1:0]}};
        end
        out_fb_high = (out_fb_high | stuck_hi) & ~gnd_flt;
        out_overcurrent = oc_flt & out_drive;
        supply_present = supply_on & ~(supply_cut & cut_works);
        supply_in_range = volt_ok;
    end
endmodule // sosd_partner

// >>> sim/tb_top.sv
// self-checking bench of the safety output supervisor
`timescale 1ns/100ps
`include "sosd_regs.svh"
module tb_top;
    localparam int PULSE = 8;
    localparam int HOLD = 50;
    localparam logic [11:0] CTRL = `SOSD_CTRL_OFS;
    localparam logic [11:0] CMD = `SOSD_CMD_OFS;
    localparam logic [11:0] STAT = `SOSD_STAT_OFS;
    localparam logic [11:0] IRQ = `SOSD_IRQ_OFS;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, v;
    logic pready, pslverr, er, supply_present, supply_in_range, supply_cut, irq;
    logic [3:0] out_fb_high, out_overcurrent, out_drive;
    logic supply_on = 1'b1, cut_works = 1'b1, volt_ok = 1'b1, short01 = 1'b0;
    logic [3:0] stuck_hi = 4'h0, gnd_flt = 4'h0, oc_flt = 4'h0;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    sosd_top #(.N(4), .PULSE_CYC(PULSE), .PERIOD_CYC(40), .HOLD_CYC(HOLD), .TEST_CYC(20)) u_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .out_fb_high(out_fb_high), .out_overcurrent(out_overcurrent), .supply_present(supply_present),
        .supply_in_range(supply_in_range), .out_drive(out_drive), .supply_cut(supply_cut), .irq(irq)
    );
    sosd_partner #(.N(4)) u_far (
        .out_drive(out_drive), .supply_cut(supply_cut), .supply_on(supply_on), .cut_works(cut_works),
        .volt_ok(volt_ok), .stuck_hi(stuck_hi), .gnd_flt(gnd_flt), .short01(short01), .oc_flt(oc_flt),
        .out_fb_high(out_fb_high), .out_overcurrent(out_overcurrent),
        .supply_present(supply_present), .supply_in_range(supply_in_range)
    );

    // ---------------
    // common tasks
    // ---------------
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // request held until pready is sampled high, for at most 20 cycles
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("pready", 32'(pready), 32'h1);
        v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst;
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        chk("rst", 32'({out_drive, supply_cut, irq}), 32'h0);
    endtask

    // bounded wait for the cut-off request to reach a level
    task automatic wt(input logic lvl, input int lim);
        int n;
        n = 0;
        while (supply_cut !== lvl && n < lim)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("cut", 32'(supply_cut), 32'(lvl));
    endtask

    // ---------------
    // scenarios
    // ---------------
    task automatic t_fail;
        cut_works <= 1'b0;
        rst();
        apb(1'b1, CTRL, 32'h2);
        cyc(40);
        apb(1'b1, CMD, 32'hF);
        cyc(5);
        chk("fail_drv", 32'(out_drive), 32'h0);
        apb(1'b0, STAT, 32'h0);
        chk("fail_stat", 32'(v[3]), 32'h1);
        cut_works <= 1'b1;
        $display("t_fail done");
    endtask

    task automatic t_late;
        supply_on <= 1'b0;
        rst();
        apb(1'b1, CTRL, 32'h2);
        cyc(30);
        chk("late_idle", 32'(supply_cut), 32'h0);
        supply_on <= 1'b1;
        wt(1'b1, 10);
        wt(1'b0, 30);
        apb(1'b0, STAT, 32'h0);
        chk("late_stat", 32'(v[3:2]), 32'h1);
        $display("t_late done");
    endtask

    task automatic t_early;
        logic seen;
        rst();
        cyc(10);
        chk("early_idle", 32'(supply_cut), 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmap_err", 32'(er), 32'h1);
        chk("unmap_dat", v, 32'h0);
        apb(1'b1, CTRL, 32'h2);
        wt(1'b1, 10);
        wt(1'b0, 30);
        apb(1'b1, CTRL, 32'h0);
        apb(1'b1, CTRL, 32'h2);
        seen = 1'b0;
        repeat (40)
        begin
            @(posedge ref_clk);
            seen = seen | supply_cut;
        end
        chk("once", 32'(seen), 32'h0);
        $display("t_early done");
    endtask

    task automatic t_pulse;
        int w;
        int n;
        apb(1'b1, CMD, 32'h1);
        cyc(5);
        w = 0;
        repeat (120)
        begin
            @(posedge ref_clk);
            w += (out_drive[0] !== 1'b1);
        end
        chk("no_pulse", 32'(w), 32'h0);
        apb(1'b1, CTRL, 32'h3);
        n = 0;
        while (out_drive[0] === 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            n++;
        end
        w = 0;
        while (out_drive[0] === 1'b0 && w < 100)
        begin
            @(posedge ref_clk);
            w++;
        end
        chk("pulse_w", 32'(w), 32'(PULSE));
        apb(1'b1, CTRL, 32'h2);
        apb(1'b1, CMD, 32'h0);
        $display("t_pulse done");
    endtask

    task automatic clean;
        stuck_hi <= 4'h0;
        gnd_flt <= 4'h0;
        short01 <= 1'b0;
        oc_flt <= 4'h0;
        volt_ok <= 1'b1;
        apb(1'b1, CMD, 32'h0);
        cyc(HOLD + 20);
        apb(1'b1, IRQ, 32'hF);
    endtask

    // cases: OFF stuck high, ON stuck high, ON grounded, mixed short
    task automatic t_wiring;
        int n;
        for (int pm = 0; pm < 2; pm++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                apb(1'b1, CTRL, 32'(2 + pm));
                apb(1'b1, CMD, c == 3 ? 32'h1 : (c == 0 ? 32'h0 : 32'h4));
                cyc(5);
                stuck_hi <= (c < 2) ? 4'h4 : 4'h0;
                gnd_flt <= (c == 2) ? 4'h4 : 4'h0;
                short01 <= (c == 3);
                v = 32'h0;
                n = 0;
                while (v[2] !== 1'b1 && n < 40)
                begin
                    apb(1'b0, IRQ, 32'h0);
                    n++;
                end
                chk("wiring", 32'(v[2]), (c == 1) ? 32'(pm) : 32'h1);
                if (c == 2)
                begin
                    gnd_flt <= 4'h0;
                    cyc(30);
                    apb(1'b0, `SOSD_FAULT_OFS, 32'h0);
                    chk("held", 32'(v[2]), 32'h1);
                end
                clean();
            end
        end
        apb(1'b1, CTRL, 32'h2);
        $display("t_wiring done");
    endtask

    task automatic t_dual;
        apb(1'b1, `SOSD_MODE_OFS, 32'h1);
        apb(1'b1, CMD, 32'h1);
        cyc(5);
        chk("dual_on", 32'(out_drive[1:0]), 32'h3);
        gnd_flt <= 4'h2;
        cyc(40);
        chk("dual_off", 32'(out_drive[1:0]), 32'h0);
        apb(1'b1, `SOSD_MODE_OFS, 32'h0);
        clean();
        $display("t_dual done");
    endtask

    task automatic t_oc;
        apb(1'b1, CMD, 32'h8);
        apb(1'b1, `SOSD_MASK_OFS, 32'hF);
        chk("oc_on", 32'(out_drive[3]), 32'h1);
        oc_flt <= 4'h8;
        cyc(10);
        chk("oc_off", 32'(out_drive[3]), 32'h0);
        apb(1'b0, IRQ, 32'h0);
        chk("oc_ev", 32'(v[0]), 32'h1);
        chk("irq_mask", 32'(irq), 32'h0);
        apb(1'b1, `SOSD_MASK_OFS, 32'h0);
        cyc(2);
        chk("irq_on", 32'(irq), 32'h1);
        clean();
        cyc(2);
        chk("irq_clr", 32'(irq), 32'h0);
        $display("t_oc done");
    endtask

    task automatic t_supply;
        apb(1'b1, CMD, 32'hF);
        cyc(5);
        volt_ok <= 1'b0;
        cyc(10);
        chk("volt_off", 32'(out_drive), 32'h0);
        apb(1'b0, STAT, 32'h0);
        chk("volt_err", 32'(v[1]), 32'h1);
        clean();
        apb(1'b1, `SOSD_UNUSED_OFS, 32'hF);
        volt_ok <= 1'b0;
        cyc(20);
        apb(1'b0, IRQ, 32'h0);
        chk("volt_unused", 32'(v[1]), 32'h0);
        $display("t_supply done");
    endtask

    initial
    begin
        t_fail();
        t_late();
        t_early();
        t_pulse();
        t_wiring();
        t_dual();
        t_oc();
        t_supply();
        wrap_up();
    end
endmodule // tb_top
